// ---- design/spd_eeprom_pkg.sv ----
// constants, types and encodings for the serial presence-detect eeprom slave
// assumes one system clock at 250 MHz and a master-driven serial clock
`default_nettype none
package spd_eeprom_pkg;
    // select byte fields, msb received first
    localparam logic [3:0] TYPE_MEM      = 4'ha;    // memory array
    localparam logic [3:0] TYPE_PROT     = 4'h6;    // protection register
    localparam logic [2:0] BIT_LAST      = 3'h7;    // eighth bit of a byte
    localparam logic [2:0] BIT_STEP      = 3'h1;
    localparam logic [3:0] PAGE_STEP     = 4'h1;    // low-nibble page increment
    localparam logic [7:0] ADDR_STEP     = 8'h01;   // full counter increment
    localparam logic [7:0] PROT_RD_BYTE  = 8'h00;   // read-back of protection reg
    localparam int         PAGE_BYTES    = 16;
    localparam int         MEM_BYTES     = 256;
    localparam int         PIN_W         = 7;

    // self-timed programming cycle
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_TIME_NS  = 5000000;        // plain default, not characterised
    localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX   = 3'h1,
        ST_ACK  = 3'h2,
        ST_TX   = 3'h3,
        ST_RACK = 3'h4,
        ST_BUSY = 3'h5
    } state_e;

    // which byte of a command is in flight
    typedef enum logic [1:0] {
        PH_SEL  = 2'h0,
        PH_ADDR = 2'h1,
        PH_DATA = 2'h2
    } phase_e;

    // select_byte layout
    typedef struct packed {
        logic [3:0] kind;
        logic [2:0] chip;
        logic       rd;
    } select_byte_s;

    // pin inputs crossing into the system clock domain
    typedef struct packed {
        logic       sda;
        logic       scl;
        logic       tog;
        logic       write_guard_n;
        logic [2:0] straps;
    } pins_s;
endpackage : spd_eeprom_pkg
`default_nettype wire

// ---- design/spd_serial_eeprom_slave.sv ----
// two-wire slave front end of a 256-byte presence-detect memory
// assumes an open-drain data line resolved outside and a master-made serial clock
// Notes on behaviour
// - transmitter releases data, receiver acks ninth clock
// - sample data on rising clock edge
// - first byte type selects array or protection
// - respond only when chip bits match straps
// - eighth select bit: one read, zero write
// - matching select byte acknowledged on ninth bit
// - writes accepted only with write guard low
// - protection write locks locations 00h to 7Fh
// - protection address and data bytes are ignored
// - lock is permanent, guard level irrelevant
// - locked device ignores protection type select
// - write: ack select, address, then data
// - programming starts only on stop after data ack
// - busy programming ignores bus entirely
// - protected location data gets no-ack, unchanged
// - page write increments only low nibble
// - select is not acked while programming
// - reads work under any protection
// - current read outputs counter, then increments
// - random read uses dummy write then restart
// - start and stop are data edges, clock high
// - sequential read continues, wraps to 00h
// - read no-ack ends transfer to standby
`default_nettype none
module spd_serial_eeprom_slave #(
    parameter int unsigned PROG_CYCLES = spd_eeprom_pkg::PROG_CYCLES
) (
    // system clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // serial clock from the master, link domain clock
    input  wire logic       scl_clk,
    // open-drain serial data
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    // board straps and write guard
    input  wire logic [2:0] chip_address_straps,
    input  wire logic       write_guard_n,
    // nonvolatile lock state, kept outside across power cycles
    input  wire logic       lock_restore,
    output logic            lock_state
);
    import spd_eeprom_pkg::*;

    // link domain: bit capture on rising serial clock
    logic rx_bit_q;   // last sampled data bit
    logic tog_q;      // flips once per rising edge

    // sample data on the rising edge; a toggle marks the new bit
    always_ff @(posedge scl_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_bit_q <= 1'b0;
            tog_q    <= 1'b0;
        end else begin
            rx_bit_q <= sda_i;
            tog_q    <= ~tog_q;
        end
    end

    // system domain: three-stage synchronisers with agreement filter
    pins_s pin_raw;
    pins_s sync1_q;   // read only by sync2_q
    pins_s sync2_q;
    pins_s sync3_q;
    pins_s filt_q;    // filtered levels
    pins_s prev_q;    // previous filtered levels

    // a bit counts once the second and third stages agree
    function automatic pins_s agree(input pins_s s2, input pins_s s3, input pins_s f);
        logic [PIN_W-1:0] r;
        r = f;
        for (int i = 0; i < PIN_W; i++) begin
            if (s2[i] == s3[i]) begin
                r[i] = s3[i];
            end
        end
        return pins_s'(r);
    endfunction : agree

    assign pin_raw = '{sda: sda_i, scl: scl_clk, tog: tog_q,
                       write_guard_n: write_guard_n, straps: chip_address_straps};

    // synchroniser chain; reset to a released bus
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= '{sda: 1'b1, scl: 1'b1, default: '0};
            sync2_q <= '{sda: 1'b1, scl: 1'b1, default: '0};
            sync3_q <= '{sda: 1'b1, scl: 1'b1, default: '0};
            filt_q  <= '{sda: 1'b1, scl: 1'b1, default: '0};
            prev_q  <= '{sda: 1'b1, scl: 1'b1, default: '0};
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= agree(sync2_q, sync3_q, filt_q);
            prev_q  <= filt_q;
        end
    end

    // bus events derived from filtered levels
    logic start_evt;
    logic stop_evt;
    logic bit_evt;
    logic scl_fall;
    logic guard_ok;
    // data edges while the clock stays high mark start and stop
    assign start_evt = prev_q.sda & ~filt_q.sda & filt_q.scl & prev_q.scl;
    assign stop_evt  = ~prev_q.sda & filt_q.sda & filt_q.scl & prev_q.scl;
    assign bit_evt   = filt_q.tog ^ prev_q.tog;
    assign scl_fall  = prev_q.scl & ~filt_q.scl;
    assign guard_ok  = ~filt_q.write_guard_n;   // low guard permits writes

    // protocol state
    state_e       state_q;
    phase_e       phase_q;
    logic [2:0]   bit_cnt_q;
    logic [7:0]   rx_sh_q;
    logic [7:0]   rx_byte;
    select_byte_s last_sel_q;   // select byte of the current command
    logic         ack_q;        // answer for the pending ninth bit
    logic         ack_w;
    logic         drive_q;      // pulling data low
    logic [7:0]   addr_q;       // shared write pointer and read counter
    logic [7:0]   tx_sh_q;
    logic         lock_q;
    logic         prog_arm_q;
    logic         prot_pend_q;
    logic [31:0]  busy_cnt_q;
    logic         busy_done;
    logic         byte_done;
    logic         rd_load;
    logic [7:0]   mem_q      [MEM_BYTES];
    logic [7:0]   page_buf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_mask_q;

    // lower half locked, or guard high, refuses a memory write
    function automatic logic wr_allowed(input logic [7:0] a, input logic lk, input logic g);
        return g & ~(lk & ~a[7]);
    endfunction : wr_allowed

    assign rx_byte   = {rx_sh_q[6:0], rx_bit_q};
    assign byte_done = (state_q == ST_RX) & bit_evt & (bit_cnt_q == BIT_LAST);
    assign busy_done = (state_q == ST_BUSY) & (busy_cnt_q == 32'(PROG_CYCLES - 1));
    // a byte is fetched after the select ack or after a master ack
    assign rd_load   = ((state_q == ST_ACK) & bit_evt & ack_q & (phase_q == PH_SEL) & last_sel_q.rd)
                     | ((state_q == ST_RACK) & bit_evt & ~rx_bit_q);

    // acknowledge decision at the eighth bit
    always_comb begin
        select_byte_s sb;
        sb    = select_byte_s'(rx_byte);
        ack_w = 1'b0;
        case (phase_q)
            PH_SEL: begin
                // protection type vanishes once locked
                ack_w = ((sb.kind == TYPE_MEM) | ((sb.kind == TYPE_PROT) & ~lock_q))
                      & (sb.chip == filt_q.straps);
            end
            PH_ADDR: begin
                ack_w = 1'b1;
            end
            default: begin
                // protection data only needs the guard; array data needs a writable cell
                ack_w = (last_sel_q.kind == TYPE_PROT) ? guard_ok
                                                       : wr_allowed(addr_q, lock_q, guard_ok);
            end
        endcase
    end

    // main sequencer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ST_IDLE;
            phase_q    <= PH_SEL;
            bit_cnt_q  <= 3'h0;
            rx_sh_q    <= 8'h00;
            last_sel_q <= '0;
            ack_q      <= 1'b0;
        end else if (state_q == ST_BUSY) begin
            // deaf to both lines until the cell write ends
            if (busy_done) begin
                state_q <= ST_IDLE;
            end
        end else if (start_evt) begin
            state_q   <= ST_RX;
            phase_q   <= PH_SEL;
            bit_cnt_q <= 3'h0;
        end else if (stop_evt) begin
            // only a stop in the slot after a data ack programs
            state_q <= prog_arm_q ? ST_BUSY : ST_IDLE;
        end else if (bit_evt) begin
            case (state_q)
                ST_RX: begin
                    rx_sh_q   <= rx_byte;
                    bit_cnt_q <= 3'(bit_cnt_q + BIT_STEP);
                    if (bit_cnt_q == BIT_LAST) begin
                        state_q <= ST_ACK;
                        ack_q   <= ack_w;
                        if (phase_q == PH_SEL) begin
                            last_sel_q <= select_byte_s'(rx_byte);
                        end
                    end
                end
                ST_ACK: begin
                    bit_cnt_q <= 3'h0;
                    if (!ack_q) begin
                        state_q <= ST_IDLE;   // deselected or refused
                    end else if ((phase_q == PH_SEL) && last_sel_q.rd) begin
                        state_q <= ST_TX;
                    end else begin
                        state_q <= ST_RX;
                        phase_q <= (phase_q == PH_SEL) ? PH_ADDR : PH_DATA;
                    end
                end
                ST_TX: begin
                    bit_cnt_q <= 3'(bit_cnt_q + BIT_STEP);
                    if (bit_cnt_q == BIT_LAST) begin
                        state_q <= ST_RACK;
                    end
                end
                ST_RACK: begin
                    // master ack continues, no-ack drops to standby
                    state_q <= rx_bit_q ? ST_IDLE : ST_TX;
                end
                default: begin
                    state_q <= state_q;   // idle ignores clocks
                end
            endcase
        end
    end

    // address pointer: loaded by address byte, page nibble on writes, full on reads
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= 8'h00;
        end else if (byte_done && (phase_q == PH_ADDR) && (last_sel_q.kind == TYPE_MEM)) begin
            addr_q <= rx_byte;   // dummy write for random read
        end else if (byte_done && (phase_q == PH_DATA) && (last_sel_q.kind == TYPE_MEM)) begin
            addr_q[3:0] <= 4'(addr_q[3:0] + PAGE_STEP);
        end else if (rd_load && (last_sel_q.kind == TYPE_MEM)) begin
            addr_q <= 8'(addr_q + ADDR_STEP);   // wraps past the top
        end
    end

    // transmit shift register; reads ignore all protection
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_sh_q <= 8'h00;
        end else if (rd_load) begin
            tx_sh_q <= (last_sel_q.kind == TYPE_PROT) ? PROT_RD_BYTE : mem_q[addr_q];
        end else if ((state_q == ST_TX) && bit_evt) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
    end

    // data pin changes only on the falling serial clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_q <= 1'b0;
        end else if (start_evt || stop_evt || (state_q == ST_BUSY)) begin
            drive_q <= 1'b0;
        end else if (scl_fall) begin
            case (state_q)
                ST_ACK:  drive_q <= ack_q;
                ST_TX:   drive_q <= ~tx_sh_q[7];
                default: drive_q <= 1'b0;           // released for master bits
            endcase
        end
    end
    assign sda_o    = 1'b0;
    assign sda_oe_n = ~drive_q;

    // programming is armed in the slot right after an acked data byte
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_arm_q <= 1'b0;
        end else if (start_evt || stop_evt) begin
            prog_arm_q <= 1'b0;
        end else if ((state_q == ST_ACK) && bit_evt && ack_q && (phase_q == PH_DATA)) begin
            prog_arm_q <= 1'b1;
        end else if ((state_q == ST_RX) && bit_evt && (bit_cnt_q != 3'h0)) begin
            prog_arm_q <= 1'b0;   // the clock ahead of a stop is still in-slot
        end
    end

    // protection request waits for the programming cycle; values ignored
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prot_pend_q <= 1'b0;
        end else if (busy_done || (start_evt && (state_q != ST_BUSY))) begin
            prot_pend_q <= 1'b0;
        end else if (byte_done && (phase_q == PH_DATA) && (last_sel_q.kind == TYPE_PROT) && ack_w) begin
            prot_pend_q <= 1'b1;
        end
    end

    // self-timed cycle counter
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_q <= 32'h0000_0000;
        end else if (state_q == ST_BUSY) begin
            busy_cnt_q <= 32'(busy_cnt_q + 32'h0000_0001);
        end else begin
            busy_cnt_q <= 32'h0000_0000;
        end
    end

    // lock is sticky; stored copy is merged every cycle after release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_q | lock_restore | (busy_done & prot_pend_q);
        end
    end
    assign lock_state = lock_q;

    // page latch occupancy; cleared at each new write command
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            page_mask_q <= '0;
        end else if (busy_done || ((state_q == ST_ACK) && bit_evt && (phase_q == PH_SEL))) begin
            page_mask_q <= '0;
        end else if (byte_done && (phase_q == PH_DATA) && (last_sel_q.kind == TYPE_MEM) && ack_w) begin
            page_mask_q[addr_q[3:0]] <= 1'b1;   // refused bytes never land
        end
    end

    // page latch data; no reset, contents qualified by the mask
    always_ff @(posedge sys_clk) begin
        if (byte_done && (phase_q == PH_DATA) && (last_sel_q.kind == TYPE_MEM) && ack_w) begin
            page_buf_q[addr_q[3:0]] <= rx_byte;   // overrun rewrites earlier slots
        end
    end

    // array commit at end of cycle; nonvolatile so no reset
    always_ff @(posedge sys_clk) begin
        if (busy_done) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (page_mask_q[i]) begin
                    mem_q[{addr_q[7:4], 4'(i)}] <= page_buf_q[i];
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_fall_drive;
        $rose(drive_q) |-> $past(scl_fall);
    endproperty
    a_fall_drive: assert property (p_fall_drive) else $error("data driven outside clock low");

    property p_busy_quiet;
        (state_q == ST_BUSY) |-> !drive_q && sda_oe_n;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("pin driven while programming");

    property p_chip_match;
        (state_q == ST_ACK && phase_q == PH_SEL && ack_q) |-> last_sel_q.chip == filt_q.straps;
    endproperty
    a_chip_match: assert property (p_chip_match) else $error("ack on foreign chip address");

    property p_locked_prot;
        (state_q == ST_ACK && phase_q == PH_SEL && last_sel_q.kind == TYPE_PROT && lock_q) |-> !ack_q;
    endproperty
    a_locked_prot: assert property (p_locked_prot) else $error("locked device acked protection");

    property p_guard_prot;
        $rose(prot_pend_q) |-> $past(guard_ok);
    endproperty
    a_guard_prot: assert property (p_guard_prot) else $error("protection set with guard high");

    property p_lock_sticky;
        lock_q |=> lock_q [*8];
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

    property p_low_refused;
        byte_done && phase_q == PH_DATA && last_sel_q.kind == TYPE_MEM && lock_q && !addr_q[7]
            |=> state_q == ST_ACK && !ack_q;
    endproperty
    a_low_refused: assert property (p_low_refused) else $error("write to locked half acked");

    property p_busy_entry;
        $rose(state_q == ST_BUSY) |-> $past(stop_evt && prog_arm_q);
    endproperty
    a_busy_entry: assert property (p_busy_entry) else $error("programming without armed stop");

    property p_nack_end;
        (state_q == ST_RACK && bit_evt && rx_bit_q && !start_evt && !stop_evt) |=> state_q == ST_IDLE;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("read continued after no-ack");

    property p_page_fixed;
        byte_done && phase_q == PH_DATA && last_sel_q.kind == TYPE_MEM |=> addr_q[7:4] == $past(addr_q[7:4])
            && addr_q[3:0] == 4'($past(addr_q[3:0]) + PAGE_STEP);
    endproperty
    a_page_fixed: assert property (p_page_fixed) else $error("page write moved upper address");

    c_program: cover property ($rose(state_q == ST_BUSY));
    c_lock_set: cover property ($rose(lock_q));
    c_read_seq: cover property (state_q == ST_RACK && bit_evt && !rx_bit_q);
    c_deselect: cover property (state_q == ST_ACK && phase_q == PH_SEL && !ack_q && bit_evt);
endmodule : spd_serial_eeprom_slave
`default_nettype wire

// ---- test/bus_master.sv ----
// two-wire bus master model: makes the serial clock and pulls data low
// assumes a pull-up on the resolved data line in the bench
`default_nettype none
module bus_master (
    // bus lines
    output var logic scl,
    output var logic sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam time QTR = 32ns;  // a quarter of one bit time; keeps each clock phase well above the sync delay

    // idle: clock parked high, data released
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // one bit: data moves only in the low phase, sampled at the rise
    task automatic bit_io(input logic b, output logic r);
        #QTR sda_low = ~b;
        #QTR scl = 1'b1;
        r = sda;
        #(2 * QTR) scl = 1'b0;
    endtask : bit_io

    // start or repeated start: data falls while clock high
    task automatic start();
        #QTR sda_low = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b1;
        #QTR scl = 1'b0;
    endtask : start

    // stop: data rises while clock high, clock then stands still
    task automatic stop();
        #QTR sda_low = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b0;
        #QTR;
    endtask : stop

    // byte out msb first, line released for the ack slot
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send

    // byte in; ack low to go on, released to end the read
    task automatic recv(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(~more, r);
    endtask : recv
endmodule : bus_master
`default_nettype wire

// ---- test/spd_serial_eeprom_slave_tb.sv ----
// self-checking bench for the two-wire eeprom slave front end
// assumes bus_master as the far side and an open-drain data line
`default_nettype none
module spd_serial_eeprom_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spd_eeprom_pkg::*;
    localparam int unsigned PROG  = 50;     // short programming time
    localparam int          LIMIT = 60000;  // cycle ceiling for the run
    logic       sys_clk;
    logic       rst_b;
    logic [2:0] straps;      // board straps
    logic       guard_n;     // low permits writes
    logic       lock_nv;     // lock kept across resets
    logic       scl;
    logic       m_low;       // master pulls data low
    logic       sda_oe_n;
    logic       sda_o;       // open-drain value while pulling
    logic       lock_state;
    logic       locked;      // bench's own record of the lock
    wire  logic sda = ~m_low & (sda_oe_n | sda_o);  // pull-up wins when released
    logic [7:0] mem [256];   // expected array contents
    int         mismatches;
    int         comparisons;
    int         cycles;

    spd_serial_eeprom_slave #(.PROG_CYCLES(PROG)) u_spd_serial_eeprom_slave (
        .sys_clk(sys_clk), .rst_b(rst_b), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .chip_address_straps(straps), .write_guard_n(guard_n), .lock_restore(lock_nv), .lock_state(lock_state));
    bus_master u_bus_master (.scl(scl), .sda_low(m_low), .sda(sda));

    // 250 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // lock survives power cycles like the real cell; hang guard
    always @(posedge sys_clk) begin
        if (lock_state === 1'b1) lock_nv <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // reset held three cycles, then synchroniser fill
    task automatic do_reset();
        @(negedge sys_clk) rst_b = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : do_reset

    task automatic sel(input logic [3:0] kind, input logic rd, output logic ack);
        u_bus_master.start();
        u_bus_master.send({kind, straps, rd}, ack);
    endtask : sel

    // write n bytes from a; acks and contents follow guard and lock
    task automatic wr(input logic [7:0] a, input logic [7:0] d0, input int n);
        logic       ack;
        logic       ok;
        logic [7:0] p;
        sel(TYPE_MEM, 1'b0, ack);
        check({7'h00, ack}, 8'h01);
        u_bus_master.send(a, ack);
        check({7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            p = {a[7:4], a[3:0] + i[3:0]};
            ok = (guard_n == 1'b0) && !(locked && !p[7]);
            u_bus_master.send(d0 + i[7:0], ack);
            check({7'h00, ack}, {7'h00, ok});
            if (ok) mem[p] = d0 + i[7:0];
        end
        u_bus_master.stop();
    endtask : wr

    // poll with write selects until acked; stop after select arms nothing
    task automatic poll(output logic first);
        logic ack;
        ack = 1'b0;
        for (int i = 0; i < 8 && !ack; i++) begin
            sel(TYPE_MEM, 1'b0, ack);
            u_bus_master.stop();
            if (i == 0) first = ack;
        end
        check({7'h00, ack}, 8'h01);
    endtask : poll

    // random read: dummy write, restart, acks all but the last byte
    task automatic rd(input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] b;
        sel(TYPE_MEM, 1'b0, ack);
        u_bus_master.send(a, ack);
        sel(TYPE_MEM, 1'b1, ack);
        check({7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            u_bus_master.recv(i < n - 1, b);
            check(b, mem[a + i[7:0]]);
        end
        u_bus_master.stop();
    endtask : rd

    // byte write: first poll lands in the busy window
    task automatic t_write_poll();
        logic first;
        wr(8'h10, 8'h5A, 1);
        poll(first);
        check({7'h00, first}, 8'h00);
        rd(8'h10, 1);
    endtask : t_write_poll

    // page write up to the page end, then wrap of the read counter
    task automatic t_page_wrap();
        logic       first;
        logic       ack;
        logic [7:0] b;
        wr(8'h2C, 8'hC0, 4);
        poll(first);
        rd(8'h2C, 2);
        rd(8'h2E, 2);
        wr(8'hFF, 8'h11, 1);
        poll(first);
        wr(8'h00, 8'h22, 2);
        poll(first);
        rd(8'hFF, 2);
        sel(TYPE_MEM, 1'b1, ack);
        u_bus_master.recv(1'b0, b);
        u_bus_master.stop();
        check(b, mem[8'h01]);
    endtask : t_page_wrap

    // guard high refuses data but not reads; foreign straps are ignored
    task automatic t_guard_straps();
        logic first;
        logic ack;
        wr(8'h40, 8'h33, 1);
        poll(first);
        @(negedge sys_clk) guard_n = 1'b1;
        wr(8'h40, 8'h99, 1);
        poll(first);
        rd(8'h40, 1);
        @(negedge sys_clk) guard_n = 1'b0;
        u_bus_master.start();
        u_bus_master.send({TYPE_MEM, ~straps, 1'b1}, ack);
        u_bus_master.stop();
        check({7'h00, ack}, 8'h00);
    endtask : t_guard_straps

    // protection register: read, lock, then lower half closed for good
    task automatic t_lock();
        logic       first;
        logic       ack;
        logic [7:0] b;
        @(negedge sys_clk) straps = 3'h2;
        sel(TYPE_PROT, 1'b1, ack);
        check({7'h00, ack}, 8'h01);
        u_bus_master.recv(1'b0, b);
        u_bus_master.stop();
        check(b, PROT_RD_BYTE);
        sel(TYPE_PROT, 1'b0, ack);
        u_bus_master.send(8'hA5, ack);
        u_bus_master.send(8'h3C, ack);
        check({7'h00, ack}, 8'h01);
        u_bus_master.stop();
        poll(first);
        locked = 1'b1;
        check({7'h00, lock_state}, 8'h01);
        wr(8'h10, 8'h77, 1);
        poll(first);
        wr(8'h90, 8'h66, 1);
        poll(first);
        sel(TYPE_PROT, 1'b0, ack);
        u_bus_master.stop();
        check({7'h00, ack}, 8'h00);
        do_reset();
        check({7'h00, lock_state}, 8'h01);
        rd(8'h10, 1);
        rd(8'h90, 1);
    endtask : t_lock

    initial begin
        rst_b = 1'b0;
        straps = 3'h5;
        guard_n = 1'b0;
        lock_nv = 1'b0;
        locked = 1'b0;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        do_reset();
        t_write_poll();
        t_page_wrap();
        t_guard_straps();
        t_lock();
        stop_test();
    end
endmodule : spd_serial_eeprom_slave_tb
`default_nettype wire
